/* rtl/irq_sources_reset_flags.sv */
/*
  Interrupt sources, reset-cause flags and context capture for an 8-bit core.
  Assumes one 20 MHz clock, a core on the same clock and asynchronous pins.
*/
// Behaviour
// - Priority enable selects two-level or single-level interrupts
// - Reset-cause flags held in bits four to zero
// - Bit five reads zero, ignores writes
// - Reset values per field; timeout, power-down read-only
// - External inputs edge-triggered, edge chosen per bit
// - Valid edge sets external flag
// - Disabled external interrupt never reaches core
// - Enabled external interrupt wakes from idle/sleep
// - Vectoring after wake only with global enable
// - Lines one, two prioritised; line zero always high
// - Eight-bit mode: FF to 00 sets flag
// - Sixteen-bit mode: FFFF to 0000 sets flag
// - Counter interrupt has enable and priority bits
// - Upper port pin change sets change flag
// - Change needs port and per-pin enables; priority
// - Return address pushed on interrupt entry
// - Working, status, bank copied to shadow stack
`include "irq_sources_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module irq_sources_reset_flags
  import irq_sources_pkg::*;
#(
  parameter int PC_W = 21 // Return address width
)
(
  input wire logic i_clock, // 20 MHz system clock
  input wire logic i_rst_n, // Synchronous reset, active low
  input wire reg_addr_t i_addr, // Register address
  input wire byte_t i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output byte_t o_rdata, // Read data, cycle after strobe
  input wire logic [2:0] i_ext_irq_line, // External interrupt pins 2..0
  input wire logic [3:0] i_second_io_port, // Upper port pins 7..4
  input wire logic i_count_tick, // Counter increment pulse
  input wire logic i_reset_instr_evt, // Reset instruction executed
  input wire logic i_wdt_timeout_evt, // Watchdog timed out
  input wire logic i_sleep_evt, // Sleep instruction executed
  input wire logic i_wdt_clear_evt, // Watchdog cleared
  input wire logic i_brownout_evt, // Brown-out seen
  input wire logic i_irq_entry, // Core enters an interrupt
  input wire logic [PC_W-1:0] i_return_pc, // Address to return to
  input wire byte_t i_working_register, // Working register
  input wire byte_t i_status, // Status register
  input wire byte_t i_bank_select_register, // Bank select register
  output logic o_irq_high, // High-priority request
  output logic o_irq_low, // Low-priority request
  output logic o_wake, // Wake from idle or sleep
  output logic o_stack_push, // Return stack push pulse
  output logic [PC_W-1:0] o_stack_pc, // Address pushed
  output byte_t o_shadow_working, // Fast stack working copy
  output byte_t o_shadow_status, // Fast stack status copy
  output byte_t o_shadow_bank // Fast stack bank copy
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (PC_W < 1 || PC_W > 32)
  begin : g_bad_pc
    $error("PC_W must be 1 to 32");
  end

  // Address match, used by every write path; the read port decodes with a case
  function automatic logic hit(input reg_addr_t a, input reg_addr_t ofs);
    hit = (a == ofs);
  endfunction : hit

  byte_t reset_cause_reg; // Priority enable and reset cause
  byte_t ctrl_one_reg; // Global enables, core flags
  byte_t ctrl_two_reg; // Edges and priorities
  byte_t ctrl_three_reg; // Lines one, two
  byte_t pin_change_en_reg; // Per-pin change enables
  byte_t count_low_reg; // Counter low byte
  byte_t count_high_reg; // Counter high byte
  byte_t count_ctrl_reg; // Run and mode
  logic [2:0] ext_meta_reg; // First sync stage
  logic [2:0] ext_sync_reg; // Second sync stage
  logic [2:0] ext_prev_reg; // Level one cycle back
  logic [3:0] pc_meta_reg; // First sync stage
  logic [3:0] pc_sync_reg; // Second sync stage
  logic [3:0] pc_prev_reg; // Level one cycle back
  logic [2:0] ext_edge; // Valid edge per line
  logic pin_change; // Any enabled pin changed
  logic cnt_ovf; // Counter rolled over
  logic [15:0] count_next; // Counter plus one
  logic wr_c1; // Write to control one
  logic wr_c3; // Write to control three

  assign wr_c1 = i_wr && hit(i_addr, `OFS_CTRL_ONE);
  assign wr_c3 = i_wr && hit(i_addr, `OFS_CTRL_THREE);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Pins are asynchronous; the first stage never feeds detection.
  // The chain stays out of reset so it already holds the pin levels when
  // reset lifts; clearing it would fake an edge on idle-high pins
  always_ff @(posedge i_clock)
  begin
    ext_meta_reg <= i_ext_irq_line;
    ext_sync_reg <= ext_meta_reg;
    ext_prev_reg <= ext_sync_reg;
    pc_meta_reg <= i_second_io_port;
    pc_sync_reg <= pc_meta_reg;
    pc_prev_reg <= pc_sync_reg;
  end

  // ----------------------------------------
  // Edge and change detection
  // ----------------------------------------
  // Edge select bits sit at descending positions for lines 0..2
  for (genvar k = 0; k < 3; k++)
  begin : g_edge
    logic sel;
    assign sel = ctrl_two_reg[`C2_EDGE0 - k];
    // Rising when select is 1, falling when 0
    assign ext_edge[k] = sel ? (ext_sync_reg[k] && !ext_prev_reg[k])
                             : (!ext_sync_reg[k] && ext_prev_reg[k]);
  end

  // Only pins with their own enable can raise the change flag
  assign pin_change = |((pc_sync_reg ^ pc_prev_reg) & pin_change_en_reg[7:4]);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // In 8-bit mode the high byte is left alone
  assign count_next = {count_high_reg, count_low_reg} + 16'h0001;
  assign cnt_ovf = i_count_tick && count_ctrl_reg[`CC_RUN] &&
                   (count_ctrl_reg[`CC_MODE8] == cnt_8bit ?
                    (count_low_reg == 8'hff) :
                    ({count_high_reg, count_low_reg} == 16'hffff));

  // Software writes take precedence over a tick in the same cycle
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      count_low_reg <= 8'h00;
      count_high_reg <= 8'h00;
      count_ctrl_reg <= `CC_RESET;
    end
    else
    begin
      if (i_wr && hit(i_addr, `OFS_COUNT_CTRL))
      begin
        count_ctrl_reg <= i_wdata & 8'hc0;
      end
      if (i_wr && hit(i_addr, `OFS_COUNT_LOW))
      begin
        count_low_reg <= i_wdata;
      end
      else if (i_count_tick && count_ctrl_reg[`CC_RUN])
      begin
        count_low_reg <= count_next[7:0];
      end
      if (i_wr && hit(i_addr, `OFS_COUNT_HIGH))
      begin
        count_high_reg <= i_wdata;
      end
      else if (i_count_tick && count_ctrl_reg[`CC_RUN] &&
               count_ctrl_reg[`CC_MODE8] == cnt_16bit)
      begin
        count_high_reg <= count_next[15:8];
      end
    end
  end

  // ----------------------------------------
  // Reset cause register
  // ----------------------------------------
  // Hardware events beat a software write in the same cycle
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      reset_cause_reg <= `RC_RESET;
    end
    else
    begin
      if (i_wr && hit(i_addr, `OFS_RESET_CAUSE))
      begin
        reset_cause_reg[`RC_PRIO_EN] <= i_wdata[`RC_PRIO_EN];
        reset_cause_reg[`RC_SOFT_BO] <= i_wdata[`RC_SOFT_BO];
        reset_cause_reg[`RC_RESET_INSTR] <= i_wdata[`RC_RESET_INSTR];
        reset_cause_reg[`RC_POWER_ON] <= i_wdata[`RC_POWER_ON];
        reset_cause_reg[`RC_BROWNOUT] <= i_wdata[`RC_BROWNOUT];
        // Timeout and power-down are read-only; bit 5 stays zero
      end
      if (i_reset_instr_evt)
      begin
        reset_cause_reg[`RC_RESET_INSTR] <= 1'b0;
      end
      if (i_wdt_clear_evt)
      begin
        reset_cause_reg[`RC_WDT_TIMEOUT] <= 1'b1;
        reset_cause_reg[`RC_POWER_DOWN] <= 1'b1;
      end
      if (i_sleep_evt)
      begin
        reset_cause_reg[`RC_WDT_TIMEOUT] <= 1'b1;
        reset_cause_reg[`RC_POWER_DOWN] <= 1'b0;
      end
      if (i_wdt_timeout_evt)
      begin
        reset_cause_reg[`RC_WDT_TIMEOUT] <= 1'b0;
      end
      if (i_brownout_evt)
      begin
        reset_cause_reg[`RC_BROWNOUT] <= 1'b0;
      end
      reset_cause_reg[`RC_UNUSED] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control registers and flags
  // ----------------------------------------
  // Flags are set by hardware and cleared only by software;
  // a set in the clearing cycle wins so no event is lost
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      ctrl_one_reg <= `C1_RESET;
      ctrl_two_reg <= `C2_RESET;
      ctrl_three_reg <= `C3_RESET;
      pin_change_en_reg <= 8'h00;
    end
    else
    begin
      if (wr_c1)
      begin
        ctrl_one_reg <= i_wdata;
      end
      if (wr_c3)
      begin
        ctrl_three_reg <= i_wdata & `C3_MASK;
      end
      if (i_wr && hit(i_addr, `OFS_CTRL_TWO))
      begin
        ctrl_two_reg <= i_wdata & `C2_MASK;
      end
      if (i_wr && hit(i_addr, `OFS_PIN_CHANGE_EN))
      begin
        pin_change_en_reg <= i_wdata & `PCE_MASK;
      end
      if (ext_edge[0])
      begin
        ctrl_one_reg[`C1_EXT0_F] <= 1'b1;
      end
      if (cnt_ovf)
      begin
        ctrl_one_reg[`C1_CNT_F] <= 1'b1;
      end
      if (pin_change)
      begin
        ctrl_one_reg[`C1_PC_F] <= 1'b1;
      end
      if (ext_edge[1])
      begin
        ctrl_three_reg[`C3_F1] <= 1'b1;
      end
      if (ext_edge[2])
      begin
        ctrl_three_reg[`C3_F2] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Request combination
  // ----------------------------------------
  logic [4:0] req_act; // Flag and own enable per source
  logic [4:0] req_high; // Source is high priority
  logic prio_en; // Two-level mode
  logic gie_high; // Global or high enable
  logic gie_low; // Low enable in two-level mode

  assign prio_en = reset_cause_reg[`RC_PRIO_EN];
  assign gie_high = ctrl_one_reg[`C1_GIE_HIGH];
  assign gie_low = ctrl_one_reg[`C1_GIE_LOW];
  // Sources: 0 line zero, 1 line one, 2 line two, 3 counter, 4 change
  assign req_act[0] = ctrl_one_reg[`C1_EXT0_F] && ctrl_one_reg[`C1_EXT0_EN];
  assign req_act[1] = ctrl_three_reg[`C3_F1] && ctrl_three_reg[`C3_EN1];
  assign req_act[2] = ctrl_three_reg[`C3_F2] && ctrl_three_reg[`C3_EN2];
  assign req_act[3] = ctrl_one_reg[`C1_CNT_F] && ctrl_one_reg[`C1_CNT_EN];
  assign req_act[4] = ctrl_one_reg[`C1_PC_F] && ctrl_one_reg[`C1_PC_EN];
  assign req_high[0] = 1'b1;
  assign req_high[1] = ctrl_three_reg[`C3_PRIO1];
  assign req_high[2] = ctrl_three_reg[`C3_PRIO2];
  assign req_high[3] = ctrl_two_reg[`C2_CNT_PRIO];
  assign req_high[4] = ctrl_two_reg[`C2_PC_PRIO];

  // In single-level mode every source goes to the high vector
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_irq_high <= 1'b0;
      o_irq_low <= 1'b0;
      o_wake <= 1'b0;
    end
    else
    begin
      if (prio_en)
      begin
        o_irq_high <= gie_high && |(req_act & req_high);
        o_irq_low <= gie_high && gie_low && |(req_act & ~req_high);
      end
      else
      begin
        o_irq_high <= gie_high && |req_act;
        o_irq_low <= 1'b0;
      end
      // Wake ignores the global enable; an enable set late still wakes
      // only once the flag is seen, which the core must tolerate
      o_wake <= |req_act[2:0];
    end
  end

  // ----------------------------------------
  // Context capture on entry
  // ----------------------------------------
  // Shadow copies hold until the next entry: one deep only
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_stack_push <= 1'b0;
      o_stack_pc <= '0;
      o_shadow_working <= 8'h00;
      o_shadow_status <= 8'h00;
      o_shadow_bank <= 8'h00;
    end
    else
    begin
      o_stack_push <= i_irq_entry;
      if (i_irq_entry)
      begin
        o_stack_pc <= i_return_pc;
        o_shadow_working <= i_working_register;
        o_shadow_status <= i_status;
        o_shadow_bank <= i_bank_select_register;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_rd)
    begin
      case (i_addr)
        `OFS_RESET_CAUSE: o_rdata <= reset_cause_reg;
        `OFS_CTRL_ONE: o_rdata <= ctrl_one_reg;
        `OFS_CTRL_TWO: o_rdata <= ctrl_two_reg;
        `OFS_CTRL_THREE: o_rdata <= ctrl_three_reg;
        `OFS_PIN_CHANGE_EN: o_rdata <= pin_change_en_reg;
        `OFS_COUNT_LOW: o_rdata <= count_low_reg;
        `OFS_COUNT_HIGH: o_rdata <= count_high_reg;
        `OFS_COUNT_CTRL: o_rdata <= count_ctrl_reg;
        default: o_rdata <= 8'h00;
      endcase
    end
    else
    begin
      o_rdata <= 8'h00;
    end
  end

endmodule : irq_sources_reset_flags
`default_nettype wire

/* rtl/irq_sources_defs.svh */
/*
  Offsets, field positions and reset values of the interrupt-source block.
  Assumes a byte-wide register port with a 3-bit address.
*/
`ifndef IRQ_SOURCES_DEFS_SVH
`define IRQ_SOURCES_DEFS_SVH
// Register offsets
`define OFS_RESET_CAUSE 3'h0
`define OFS_CTRL_ONE 3'h1
`define OFS_CTRL_TWO 3'h2
`define OFS_CTRL_THREE 3'h3
`define OFS_PIN_CHANGE_EN 3'h4
`define OFS_COUNT_LOW 3'h5
`define OFS_COUNT_HIGH 3'h6
`define OFS_COUNT_CTRL 3'h7
// Reset cause register fields
`define RC_PRIO_EN 7
`define RC_SOFT_BO 6
`define RC_UNUSED 5
`define RC_RESET_INSTR 4
`define RC_WDT_TIMEOUT 3
`define RC_POWER_DOWN 2
`define RC_POWER_ON 1
`define RC_BROWNOUT 0
`define RC_RESET 8'h5c
// Control one fields
`define C1_GIE_HIGH 7
`define C1_GIE_LOW 6
`define C1_CNT_EN 5
`define C1_EXT0_EN 4
`define C1_PC_EN 3
`define C1_CNT_F 2
`define C1_EXT0_F 1
`define C1_PC_F 0
`define C1_RESET 8'h00
// Control two fields
`define C2_EDGE0 6
`define C2_EDGE1 5
`define C2_EDGE2 4
`define C2_CNT_PRIO 2
`define C2_PC_PRIO 0
`define C2_MASK 8'h75
`define C2_RESET 8'h75
// Control three fields
`define C3_PRIO2 7
`define C3_PRIO1 6
`define C3_EN2 4
`define C3_EN1 3
`define C3_F2 1
`define C3_F1 0
`define C3_MASK 8'hdb
`define C3_RESET 8'hc0
// Pin change enables sit in bits 7:4
`define PCE_MASK 8'hf0
// Counter control fields
`define CC_RUN 7
`define CC_MODE8 6
`define CC_RESET 8'hc0
`endif

/* rtl/irq_sources_pkg.sv */
/*
  Types shared by the interrupt-source block.
  Assumes the constants header is included where numbers are needed.
*/
package irq_sources_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] reg_addr_t;
  typedef enum logic {cnt_16bit = 1'b0, cnt_8bit = 1'b1} cnt_mode_t;
endpackage : irq_sources_pkg

/* test/irq_sources_monitor.sv */
/*
  Port checker for the interrupt-source block.
  Assumes it is bound to irq_sources_reset_flags and shares its clock.
*/
`include "irq_sources_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module irq_sources_monitor
  import irq_sources_pkg::*;
#(
  parameter int PC_W = 21 // Return address width
)
(
  input wire logic i_clock, // System clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire reg_addr_t i_addr, // Register address
  input wire byte_t i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire byte_t o_rdata, // Read data
  input wire logic i_irq_entry, // Core enters interrupt
  input wire logic [PC_W-1:0] i_return_pc, // Return address
  input wire byte_t i_working_register, // Working register
  input wire byte_t i_status, // Status register
  input wire byte_t i_bank_select_register, // Bank register
  input wire logic o_irq_high, // High request
  input wire logic o_irq_low, // Low request
  input wire logic o_wake, // Wake request
  input wire logic o_stack_push, // Push pulse
  input wire logic [PC_W-1:0] o_stack_pc, // Pushed address
  input wire byte_t o_shadow_working, // Shadow working
  input wire byte_t o_shadow_status, // Shadow status
  input wire byte_t o_shadow_bank // Shadow bank
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_push; i_irq_entry |=> o_stack_push; endproperty
  property p_push_src; o_stack_push |-> $past(i_irq_entry); endproperty
  property p_pc; i_irq_entry |=> o_stack_pc == $past(i_return_pc); endproperty
  property p_shadow;
    i_irq_entry |=> o_shadow_working == $past(i_working_register)
      && o_shadow_status == $past(i_status) && o_shadow_bank == $past(i_bank_select_register);
  endproperty
  // Bank copy and pushed address must hold between entries, the fast return depends on them
  property p_hold; !i_irq_entry |=> $stable(o_shadow_bank) && $stable(o_stack_pc); endproperty
  property p_bit5; i_rd && i_addr == `OFS_RESET_CAUSE |=> !o_rdata[`RC_UNUSED]; endproperty
  property p_gate;
    i_wr && i_addr == `OFS_CTRL_ONE && i_wdata == 8'h00 |-> ##2 !o_irq_high && !o_irq_low;
  endproperty
  property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  a_push: assert property (p_push) else $error("push missing after entry");
  a_push_src: assert property (p_push_src) else $error("push without entry");
  a_pc: assert property (p_pc) else $error("wrong pushed address");
  a_shadow: assert property (p_shadow) else $error("wrong shadow copy");
  a_hold: assert property (p_hold) else $error("shadow copy moved");
  a_bit5: assert property (p_bit5) else $error("bit five not zero");
  a_gate: assert property (p_gate) else $error("request with global enables off");
  a_idle: assert property (p_idle) else $error("read data outside read cycle");
  c_wake: cover property (o_wake);
  c_low: cover property (o_irq_low);
  c_push: cover property (o_stack_push);
endmodule : irq_sources_monitor
bind irq_sources_reset_flags irq_sources_monitor #(.PC_W(PC_W)) irq_sources_monitor_inst (
  .i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_irq_entry, .i_return_pc,
  .i_working_register, .i_status, .i_bank_select_register, .o_irq_high, .o_irq_low, .o_wake,
  .o_stack_push, .o_stack_pc, .o_shadow_working, .o_shadow_status, .o_shadow_bank);
`default_nettype wire

/* test/irq_core_model.sv */
/*
  Behavioural core that takes requests and enters the service routine.
  Assumes the bench opens the acceptance window with i_take.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_core_model #(
  parameter int PC_W = 21 // Return address width
)
(
  input wire logic i_clock, // System clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic i_take, // Core may accept a request
  input wire logic i_irq_high, // High request
  input wire logic i_irq_low, // Low request
  output logic o_entry, // Entry pulse
  output logic [PC_W-1:0] o_pc, // Return address
  output logic [7:0] o_working, // Working register
  output logic [7:0] o_status, // Status register
  output logic [7:0] o_bank // Bank register
);
  // ------------------------------------------------------------
  // Entry sequencing
  // ------------------------------------------------------------
  logic served; // One entry per acceptance window
  // Context moves every cycle so a late capture shows up
  assign o_working = o_pc[7:0];
  assign o_status = ~o_pc[7:0];
  assign o_bank = o_pc[7:0] ^ 8'h5a;
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_pc <= '0;
      o_entry <= 1'b0;
      served <= 1'b0;
    end
    else
    begin
      o_pc <= o_pc + 1'b1;
      o_entry <= i_take && (i_irq_high || i_irq_low) && !served && !o_entry;
      served <= i_take && (served || o_entry);
    end
  end
endmodule : irq_core_model
`default_nettype wire

/* test/tb_irq_sources_reset_flags.sv */
/*
  Self-checking bench for the interrupt-source block.
  Assumes the bench itself drives pins, events and the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_irq_sources_reset_flags;
  import irq_sources_pkg::*;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic clock, rst_n, wr_s, rd_s, tick, take, entry, irq_h, irq_l, wake, push;
  reg_addr_t addr;
  byte_t wdata, rdata, wk, st, bk, sw, ss, sb, ew, es, eb, v;
  logic [2:0] ext; // External pins
  logic [3:0] port; // Upper port pins
  logic [4:0] evt; // Reset-cause event pulses
  logic [20:0] ret_pc, spc, epc;
  int err_total, check_count;
  irq_sources_reset_flags irq_sources_reset_flags_inst (.i_clock(clock), .i_rst_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .i_ext_irq_line(ext), .i_second_io_port(port), .i_count_tick(tick),
    .i_reset_instr_evt(evt[0]), .i_wdt_timeout_evt(evt[1]), .i_sleep_evt(evt[2]),
    .i_wdt_clear_evt(evt[3]), .i_brownout_evt(evt[4]), .i_irq_entry(entry),
    .i_return_pc(ret_pc), .i_working_register(wk), .i_status(st), .i_bank_select_register(bk),
    .o_irq_high(irq_h), .o_irq_low(irq_l), .o_wake(wake), .o_stack_push(push),
    .o_stack_pc(spc), .o_shadow_working(sw), .o_shadow_status(ss), .o_shadow_bank(sb));
  irq_core_model irq_core_model_inst (.i_clock(clock), .i_rst_n(rst_n), .i_take(take),
    .i_irq_high(irq_h), .i_irq_low(irq_l), .o_entry(entry), .o_pc(ret_pc), .o_working(wk),
    .o_status(st), .o_bank(bk));
  // Remember what the core offered at entry
  always @(posedge clock)
    if (entry) {epc, ew, es, eb} <= {ret_pc, wk, st, bk};
  initial
  begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic wr(input reg_addr_t a, input byte_t d);
    @(posedge clock);
    {addr, wdata, wr_s} <= {a, d, 1'b1};
    @(posedge clock);
    wr_s <= 1'b0;
  endtask : wr
  // Read data is valid only in the cycle after the strobe
  task automatic rd(input reg_addr_t a, output byte_t d);
    @(posedge clock);
    {addr, rd_s} <= {a, 1'b1};
    @(posedge clock);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic tk;
    @(posedge clock);
    tick <= 1'b1;
    @(posedge clock);
    tick <= 1'b0;
  endtask : tk
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    byte_t rv[8] = '{8'h5c, 8'h00, 8'h75, 8'hc0, 8'h00, 8'h00, 8'h00, 8'hc0};
    byte_t ex[5] = '{8'hcf, 8'hc7, 8'hcb, 8'hcf, 8'hce};
    for (int i = 0; i < 8; i++)
    begin
      rd(i[2:0], v);
      chk(v, rv[i]);
    end
    wr(0, 8'hff);
    rd(0, v);
    chk(v, 8'hdf);
    // Each event pulse moves its own flag; sleep moves both timeout and power-down, watchdog clear moves only power-down here
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clock);
      evt <= 5'h01 << i;
      @(posedge clock);
      evt <= 5'h00;
      rd(0, v);
      chk(v, ex[i]);
    end
  endtask : t_regs
  task automatic t_ext(input int k);
    reg_addr_t fa = (k == 0) ? 3'h1 : 3'h3;
    int fb = (k == 0) ? 1 : k - 1;
    for (int e = 0; e < 2; e++)
    begin
      // Park the line where the wrong edge starts, so that edge is tried
      ext[k] <= e;
      cyc(4);
      wr(1, 8'h00);
      wr(3, 8'hc0);
      wr(2, (e == 1) ? 8'h75 : (8'h75 & ~(8'h40 >> k)));
      ext[k] <= !e;
      cyc(4);
      rd(fa, v);
      chk(v[fb], 1'b0);
      ext[k] <= e;
      cyc(4);
      rd(fa, v);
      chk(v[fb], 1'b1);
      chk(wake, 1'b0);
      if (k == 0) wr(1, 8'h12);
      else wr(3, 8'hc0 | (8'h09 << (k - 1)));
      cyc(2);
      chk(wake, 1'b1);
      chk(irq_h, 1'b0);
      wr(1, (k == 0) ? 8'h92 : 8'h80);
      cyc(2);
      chk(irq_h, 1'b1);
    end
    if (k == 1)
    begin
      wr(3, 8'h89);
      wr(1, 8'hc0);
      cyc(2);
      chk({irq_h, irq_l}, 2'b01);
    end
  endtask : t_ext
  task automatic t_ctx;
    int n = 0;
    take <= 1'b1;
    while (push !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #1 n++;
    end
    if (push !== 1'b1)
    begin
      err_total++;
      test_done();
    end
    chk(spc, epc);
    chk({sw, ss, sb}, {ew, es, eb});
    take <= 1'b0;
    wr(1, 8'h00);
    wr(3, 8'hc0);
  endtask : t_ctx
  task automatic t_cnt;
    wr(5, 8'hff);
    tk();
    rd(1, v);
    chk(v[2], 1'b1);
    wr(1, 8'h00);
    wr(7, 8'h80);
    wr(6, 8'hfe);
    wr(5, 8'hff);
    tk();
    rd(1, v);
    chk(v[2], 1'b0);
    rd(6, v);
    chk(v, 8'hff);
    wr(5, 8'hff);
    tk();
    rd(1, v);
    chk(v[2], 1'b1);
    wr(0, 8'h80);
    wr(2, 8'h71);
    wr(1, 8'he4);
    cyc(2);
    chk({irq_h, irq_l}, 2'b01);
    wr(0, 8'h00);
    cyc(2);
    chk({irq_h, irq_l}, 2'b10);
    wr(1, 8'hc4);
    cyc(2);
    chk({irq_h, irq_l}, 2'b00);
    wr(1, 8'h00);
  endtask : t_cnt
  task automatic t_pc;
    wr(4, 8'h10);
    port <= 4'h2;
    cyc(4);
    rd(1, v);
    chk(v[0], 1'b0);
    port <= 4'h3;
    cyc(4);
    rd(1, v);
    chk(v[0], 1'b1);
    wr(1, 8'h89);
    cyc(2);
    chk(irq_h, 1'b1);
  endtask : t_pc
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst_n, wr_s, rd_s, tick, take, evt, port} = '0;
    {addr, wdata} = '0;
    ext = 3'b111;
    err_total = 0;
    check_count = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    for (int k = 0; k < 3; k++) t_ext(k);
    t_ctx();
    t_cnt();
    t_pc();
    test_done();
  end
endmodule : tb_irq_sources_reset_flags
`default_nettype wire
